// *** logic/sms_regs.svh ***
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH
// current-select codes {msb,lsb}
`define SMS_LVL_FULL  2'h0
`define SMS_LVL_TWO3  2'h1
`define SMS_LVL_ONE3  2'h2
`define SMS_LVL_OFF   2'h3
// table lengths minus one
`define SMS_HALF_LAST 4'h7
`define SMS_QTR_LAST  4'hf
// reset values of the pins
`define SMS_RST_INDEX 4'h0
`define SMS_RST_POL   1'b0
// disable pin level that keeps a bridge driving, in reset and in use
`define SMS_BRIDGE_ON 1'b0
`endif

// *** logic/sms_pkg.sv ***
package sms_pkg;
   // excitation mode
   typedef enum logic {SMS_HALF, SMS_QUARTER} sms_mode_e;
   // two-bit current-select code
   typedef logic [1:0] sms_level_t;
endpackage : sms_pkg

// *** logic/sms_sequencer.sv ***
`timescale 1ns/1ps
`include "sms_regs.svh"
// Contract
// (RQ1) device blocks shoot-through on polarity change
// (RQ2) device applies polarity on/off delays
// (RQ3) device applies disable on/off delays
// (RQ4) shape current only by select codes
// (RQ5) hold both disable inputs low
// (RQ6) half-step uses eight-entry cycle
// (RQ7) half-step table values per entry
// (RQ8) quarter-step uses sixteen-entry cycle, B lags
// (RQ9) quarter-step winding A table values
// (RQ10) quarter-step winding B table values
// (RQ11) code 00 full, 01 2/3, 10 1/3, 11 off
// (RQ12) polarity high drives first output high
// (RQ13) outputs off when disabled or code 11
// (RQ14) one entry per step, wrap, reverse
module sms_sequencer (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // user commands, same clock domain
   input  wire logic step_in,
   input  wire logic reverse_in,
   input  wire logic quarter_mode_in,
   // driver pins
   output logic      bridge_a_polarity_out,
   output logic      bridge_a_level_msb_out,
   output logic      bridge_a_level_lsb_out,
   output logic      bridge_a_disable_n_out,
   output logic      bridge_b_polarity_out,
   output logic      bridge_b_level_msb_out,
   output logic      bridge_b_level_lsb_out,
   output logic      bridge_b_disable_n_out,
   // status
   output logic [3:0] step_index_out
);

   // reset synchroniser; rst_meta_q is read only by rst_sync_q
   // entry is immediate, release waits two edges so every flop leaves reset together
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // quarter-step entry for winding A: {polarity, code}
   function automatic logic [2:0] qtr_entry(input logic [3:0] idx);
      logic [2:0] r;
      r = {1'b0, `SMS_LVL_OFF};
      case (idx)
         4'h0, 4'h1, 4'hf: r = {1'b0, `SMS_LVL_FULL};
         4'h2, 4'he:       r = {1'b0, `SMS_LVL_TWO3};
         4'h3, 4'hd:       r = {1'b0, `SMS_LVL_ONE3};
         4'h4, 4'hc:       r = {1'b0, `SMS_LVL_OFF};
         4'h5, 4'hb:       r = {1'b1, `SMS_LVL_ONE3};
         4'h6, 4'ha:       r = {1'b1, `SMS_LVL_TWO3};
         default:          r = {1'b1, `SMS_LVL_FULL};
      endcase
      return r;
   endfunction : qtr_entry

   // half-step entry for winding A; B is the same table shifted by two
   function automatic logic [2:0] half_entry(input logic [2:0] idx);
      logic [2:0] r;
      r = {1'b0, `SMS_LVL_OFF};
      case (idx)
         3'h0:       r = {1'b0, `SMS_LVL_FULL};
         3'h1, 3'h7: r = {1'b0, `SMS_LVL_TWO3};
         3'h2, 3'h6: r = {1'b0, `SMS_LVL_OFF};
         3'h3, 3'h5: r = {1'b1, `SMS_LVL_TWO3};
         default:    r = {1'b1, `SMS_LVL_FULL};
      endcase
      return r;
   endfunction : half_entry

   // entry index and mode
   logic [3:0]             idx_q;
   logic [3:0]             idx_d;
   sms_pkg::sms_mode_e     mode_q;
   wire  logic [3:0]       last_w = (mode_q == sms_pkg::SMS_QUARTER) ? `SMS_QTR_LAST
                                                                    : `SMS_HALF_LAST;

   // next index: wrap both ways, backwards for reverse
   assign idx_d = !step_in          ? idx_q :                       // RQ14
                  reverse_in        ? ((idx_q == 4'h0) ? last_w : idx_q - 4'h1) :
                  (idx_q == last_w) ? 4'h0 : idx_q + 4'h1;

   // b lags a: quarter by four entries, half-step by two (polarity flipped
   // is folded into the shifted table since both windings share one shape)
   wire logic [3:0] qb_idx_w = idx_q - 4'h4;                          // RQ8
   wire logic [2:0] hb_idx_w = idx_q[2:0] - 3'h2;
   wire logic [2:0] qa_w     = qtr_entry(idx_q);                      // RQ9
   wire logic [2:0] qb_w     = qtr_entry(qb_idx_w);                   // RQ10
   wire logic [2:0] ha_w     = half_entry(idx_q[2:0]);                // RQ7
   wire logic [2:0] hb_w     = half_entry(hb_idx_w);                  // RQ7
   wire logic [2:0] a_w      = (mode_q == sms_pkg::SMS_QUARTER) ? qa_w : ha_w;
   wire logic [2:0] b_w      = (mode_q == sms_pkg::SMS_QUARTER) ? qb_w : hb_w;

   // mode is taken only at entry 0, on arrival or while idle there, so a cycle is never mixed
   wire logic mode_take_w = (idx_d == 4'h0) || (idx_q == 4'h0 && !step_in);
   wire logic [3:0] idx_fix_w = (quarter_mode_in ? idx_d : {1'b0, idx_d[2:0]});

   // index and mode registers; idx_fix_w equals idx_d whenever it is chosen,
   // it stays as a guard so a stale top bit can never enter half-step mode
   always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         idx_q  <= `SMS_RST_INDEX;
         mode_q <= sms_pkg::SMS_HALF;
      end else begin
         idx_q  <= mode_take_w ? idx_fix_w : idx_d;                   // RQ6
         if (mode_take_w) begin
            mode_q <= quarter_mode_in ? sms_pkg::SMS_QUARTER : sms_pkg::SMS_HALF;
         end
      end
   end

   // pin registers; the reference voltage is untouched, only codes shape current
   // no step spacing is enforced here: the user must leave at least the driver's
   // longest switching delay between steps or the winding never settles
   always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         bridge_a_polarity_out  <= `SMS_RST_POL;
         {bridge_a_level_msb_out, bridge_a_level_lsb_out} <= `SMS_LVL_OFF;
         bridge_b_polarity_out  <= `SMS_RST_POL;
         {bridge_b_level_msb_out, bridge_b_level_lsb_out} <= `SMS_LVL_OFF;
         bridge_a_disable_n_out <= `SMS_BRIDGE_ON;
         bridge_b_disable_n_out <= `SMS_BRIDGE_ON;
         step_index_out         <= `SMS_RST_INDEX;
      end else begin
         bridge_a_polarity_out  <= a_w[2];                            // RQ12
         {bridge_a_level_msb_out, bridge_a_level_lsb_out} <= a_w[1:0]; // RQ4
         bridge_b_polarity_out  <= b_w[2];
         {bridge_b_level_msb_out, bridge_b_level_lsb_out} <= b_w[1:0]; // RQ11
         bridge_a_disable_n_out <= `SMS_BRIDGE_ON;                    // RQ5
         bridge_b_disable_n_out <= `SMS_BRIDGE_ON;                    // RQ5
         step_index_out         <= idx_q;
      end
   end

   // pin codes regrouped so the checks below read like the tables
   wire logic [1:0] pin_lvl_a_w = {bridge_a_level_msb_out, bridge_a_level_lsb_out};
   wire logic [1:0] pin_lvl_b_w = {bridge_b_level_msb_out, bridge_b_level_lsb_out};

   // assertions; each one is qualified by the synchronised reset, and the ones
   // that look at the pins one edge later, only pin_track_a, half_even_a and half_odd_a also carry it
   // in the antecedent so the release edge never compares against reset values
   en_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ5
      !bridge_a_disable_n_out && !bridge_b_disable_n_out)
      else $error("disable pin driven high");
   half_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ6
      mode_q == sms_pkg::SMS_HALF |-> idx_q <= `SMS_HALF_LAST)
      else $error("half-step index out of range");
   fwd_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ14
      step_in && !reverse_in && idx_q != last_w |=> idx_q == $past(idx_q) + 4'h1)
      else $error("forward step wrong");
   rev_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ14
      step_in && reverse_in && idx_q != 4'h0 |=> idx_q == $past(idx_q) - 4'h1)
      else $error("reverse step wrong");
   hold_idx_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ14
      !step_in && idx_q != 4'h0 |=> $stable(idx_q))
      else $error("index moved without step");
   pin_track_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ4
      rst_sync_q |=> {bridge_a_polarity_out, bridge_a_level_msb_out, bridge_a_level_lsb_out}
               == $past(a_w))
      else $error("winding a pins lag table");
   qtr_full_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ9
      mode_q == sms_pkg::SMS_QUARTER && idx_q == 4'h8 |=>
      bridge_a_polarity_out && {bridge_a_level_msb_out, bridge_a_level_lsb_out} == 2'h0)
      else $error("quarter entry 8 wrong");
   qtr_b_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ10
      mode_q == sms_pkg::SMS_QUARTER && idx_q == 4'h8 |=>
      {bridge_b_level_msb_out, bridge_b_level_lsb_out} == 2'h3)
      else $error("quarter b off entry wrong");
   half_b_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ7
      mode_q == sms_pkg::SMS_HALF && idx_q == 4'h2 |=>
      !bridge_b_polarity_out && {bridge_b_level_msb_out, bridge_b_level_lsb_out} == 2'h0)
      else $error("half entry 2 b wrong");

   // the table shape itself, checked apart from the lookup functions
   half_even_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ6
      rst_sync_q && mode_q == sms_pkg::SMS_HALF && !idx_q[0] |=>
      (pin_lvl_a_w == `SMS_LVL_FULL && pin_lvl_b_w == `SMS_LVL_OFF) ||
      (pin_lvl_a_w == `SMS_LVL_OFF && pin_lvl_b_w == `SMS_LVL_FULL))
      else $error("half-step even entry wrong");
   half_odd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ6
      rst_sync_q && mode_q == sms_pkg::SMS_HALF && idx_q[0] |=>
      pin_lvl_a_w == `SMS_LVL_TWO3 && pin_lvl_b_w == `SMS_LVL_TWO3)
      else $error("half-step odd entry wrong");
   // entry four shows the lag: a has just gone off while b is at full
   qtr_lag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ8
      mode_q == sms_pkg::SMS_QUARTER && idx_q == 4'h4 |=>
      pin_lvl_a_w == `SMS_LVL_OFF && !bridge_b_polarity_out && pin_lvl_b_w == `SMS_LVL_FULL)
      else $error("quarter b lag wrong");
   // a mode swap mid-cycle would splice two tables together
   mode_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ6
      $changed(mode_q) |-> idx_q == 4'h0)
      else $error("mode changed away from index 0");
   fwd_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ14
      step_in && !reverse_in && idx_q == last_w |=> idx_q == 4'h0)
      else $error("forward wrap wrong");
   rev_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_q) // RQ14
      step_in && reverse_in && idx_q == 4'h0 |=> idx_q == $past(last_w))
      else $error("reverse wrap wrong");

   // covers
   fwd_wrap_c: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      step_in && !reverse_in && idx_q == last_w);
   rev_wrap_c: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      step_in && reverse_in && idx_q == 4'h0);
   qtr_run_c: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      mode_q == sms_pkg::SMS_QUARTER && idx_q == 4'hf);
   // a mode swap and a half-step wrap, so both tables are seen end to end
   mode_swap_c: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      $changed(mode_q));
   half_wrap_c: cover property (@(posedge sys_clk_in) disable iff (!rst_sync_q)
      step_in && mode_q == sms_pkg::SMS_HALF && idx_q == `SMS_HALF_LAST);

endmodule : sms_sequencer

// *** tb/sms_bridge_model.sv ***
`timescale 1ns/1ps
// behavioural stand-in for one bridge of the driver
module sms_bridge_model (
   // pins from the controller
   input  wire logic       polarity_in,
   input  wire logic       msb_in,
   input  wire logic       lsb_in,
   input  wire logic       disable_n_in,
   // bridge state
   output logic            bridge_out_first_out,
   output logic            bridge_out_second_out,
   output logic [1:0]      thirds_out
);
   logic blank = 1'b0; // both sides held off while switching
   // crude break-before-make: the longest on delay stands in for all of them
   always @(polarity_in or disable_n_in) begin
      blank = 1'b1;
      #10000 blank = 1'b0;
   end
   wire off = disable_n_in | (msb_in & lsb_in);
   assign thirds_out = off ? 2'h0 : 2'h3 - {msb_in, lsb_in};
   assign bridge_out_first_out = !(off | blank) & polarity_in;
   assign bridge_out_second_out = !(off | blank) & !polarity_in;
endmodule : sms_bridge_model

// *** tb/test_sms_sequencer.sv ***
`timescale 1ns/1ps
module test_sms_sequencer;
   logic sys_clk_in = 1'b0, rst_n_in = 1'b0, step_in = 1'b0;
   logic reverse_in = 1'b0, quarter_mode_in = 1'b0;
   logic pa, am, al, ad, pb, bm, bl, bd;
   logic [3:0] idx;
   logic [1:0] tha, thb;
   logic fa, sa, fb, sb;
   int num_errors = 0, n_checks = 0;
   // winding a entries as {polarity, msb, lsb}; b is the same table shifted back
   logic [2:0] half_a [8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h4, 3'h5, 3'h3, 3'h1};
   logic [2:0] qtr_a [16] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h5, 3'h4,
                              3'h4, 3'h4, 3'h5, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
   always #50 sys_clk_in = ~sys_clk_in;
   sms_sequencer sms_sequencer_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .step_in(step_in), .reverse_in(reverse_in), .quarter_mode_in(quarter_mode_in),
      .bridge_a_polarity_out(pa), .bridge_a_level_msb_out(am), .bridge_a_level_lsb_out(al),
      .bridge_a_disable_n_out(ad), .bridge_b_polarity_out(pb), .bridge_b_level_msb_out(bm),
      .bridge_b_level_lsb_out(bl), .bridge_b_disable_n_out(bd), .step_index_out(idx));
   sms_bridge_model sms_bridge_model_inst_a (.polarity_in(pa), .msb_in(am), .lsb_in(al),
      .disable_n_in(ad), .bridge_out_first_out(fa), .bridge_out_second_out(sa),
      .thirds_out(tha));
   sms_bridge_model sms_bridge_model_inst_b (.polarity_in(pb), .msb_in(bm), .lsb_in(bl),
      .disable_n_in(bd), .bridge_out_first_out(fb), .bridge_out_second_out(sb),
      .thirds_out(thb));
   task automatic cmp(string what, logic [5:0] exp, logic [5:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // compare every pin against entry i of the chosen table
   task automatic check(logic q, logic [3:0] i);
      logic [2:0] ea, eb;
      ea = q ? qtr_a[i] : half_a[i[2:0]];
      eb = q ? qtr_a[i - 4'h4] : half_a[i[2:0] - 3'h2];
      cmp("bridge a pins", {3'h0, ea}, {3'h0, pa, am, al});
      cmp("bridge b pins", {3'h0, eb}, {3'h0, pb, bm, bl});
      cmp("disables", 6'h0, {4'h0, ad, bd});
      cmp("index", {2'h0, i}, {2'h0, idx});
      cmp("thirds", {2'h0, 2'h3 - ea[1:0], 2'h3 - eb[1:0]}, {2'h0, tha, thb});
   endtask : check
   // one step strobe, then wait for the registered pins
   task automatic step(logic rev, logic q, logic [3:0] i);
      @(posedge sys_clk_in);
      step_in <= 1'b1;
      reverse_in <= rev;
      @(posedge sys_clk_in);
      step_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      check(q, i);
   endtask : step
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // a stalled run is stopped at 200000 ns and counted as a failure
   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      #1;
      cmp("reset pins", 6'h1b, {pa, am, al, pb, bm, bl});
      @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      #1;
      check(1'b0, 4'h0);
      $display("test reset done");
      for (int k = 1; k <= 8; k++) step(1'b0, 1'b0, 4'(k % 8));
      $display("test half done");
      @(posedge sys_clk_in);
      quarter_mode_in <= 1'b1;
      // dropping the mode mid-cycle must not show until the wrap
      for (int k = 1; k <= 16; k++) begin
         if (k == 6) begin
            @(posedge sys_clk_in);
            quarter_mode_in <= 1'b0;
         end
         step(1'b0, 1'b1, 4'(k % 16));
      end
      $display("test quarter done");
      // long idle so the model's switching blank has run out
      repeat (120) @(posedge sys_clk_in);
      #1;
      cmp("bridge outs", 6'h04, {2'h0, fa, sa, fb, sb});
      // b flips polarity on this step, so its outputs are still blanked
      step(1'b1, 1'b0, 4'h7);
      cmp("blanked outs", 6'h04, {2'h0, fa, sa, fb, sb});
      for (int k = 6; k >= 5; k--) step(1'b1, 1'b0, 4'(k));
      step(1'b0, 1'b0, 4'h6);
      repeat (120) @(posedge sys_clk_in);
      #1;
      cmp("bridge outs", 6'h02, {2'h0, fa, sa, fb, sb});
      $display("test reverse done");
      report_and_stop();
   end
endmodule : test_sms_sequencer
